// ===== common/emac_irq_pkg.sv
// Constants shared by the Ethernet MAC interrupt aggregator.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none
package emac_irq_pkg;
  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] RAW_STATUS_OFS = 6'h00;
  localparam logic [ADDR_W-1:0] MASKED_STATUS_OFS = 6'h04;
  localparam logic [ADDR_W-1:0] INT_CLEAR_OFS = 6'h08;
  localparam logic [ADDR_W-1:0] INT_ENABLE_OFS = 6'h0c;
  localparam logic [ADDR_W-1:0] TS_ENABLE_OFS = 6'h10;
  localparam logic [ADDR_W-1:0] TS_STATUS_OFS = 6'h14;
  localparam logic [ADDR_W-1:0] DMA_CTRL_OFS = 6'h18;
  localparam logic [ADDR_W-1:0] DMA_STATE_OFS = 6'h1c;
  localparam logic [ADDR_W-1:0] POLL_OFS = 6'h20;
  localparam logic [ADDR_W-1:0] NUM_ADDR_OFS = 6'h24;
  // Source bit positions in the status words
  localparam int TX_DONE_BIT = 0;
  localparam int TX_HALTED_BIT = 1;
  localparam int TX_NODESC_BIT = 2;
  localparam int TX_OVERLONG_BIT = 3;
  localparam int RX_OVERRUN_BIT = 4;
  localparam int TX_UNDERRUN_BIT = 5;
  localparam int RX_DONE_BIT = 6;
  localparam int RX_NODESC_BIT = 7;
  localparam int RX_HALTED_BIT = 8;
  localparam int RX_OVERSIZE_BIT = 9;
  localparam int TX_IN_FIFO_BIT = 10;
  localparam int PHY_CHANGE_BIT = 11;
  localparam int BUS_FAULT_BIT = 12;
  localparam int FIRST_RX_BUF_BIT = 13;
  localparam int TIME_SYNC_BIT = 14;
  localparam int ABNORMAL_BIT = 15;
  localparam int NORMAL_BIT = 16;
  localparam int NUM_SRC = 15;
  localparam int STATUS_W = 17;
  // Constituents of the two summaries
  localparam logic [NUM_SRC-1:0] NORMAL_SET = 15'h2045;
  localparam logic [NUM_SRC-1:0] ABNORMAL_SET = 15'h17ba;
  // Control field positions
  localparam int DMA_EN_BIT = 0;
  localparam int JUMBO_BIT = 1;
  localparam int RX_POLL_BIT = 0;
  localparam int TX_POLL_BIT = 1;
  localparam int RX_SUSP_BIT = 4;
  localparam int TX_SUSP_BIT = 5;
  localparam int CAUSE_W = 3;
  // Reset values
  localparam logic [NUM_SRC-1:0] ENABLE_RST = 15'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 3'h0;
  // Frame length limits in bytes
  localparam int NORMAL_LIMIT = 2048;
  localparam int JUMBO_LIMIT = 10240;
  // Bus slave states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } bus_state_t;
endpackage : emac_irq_pkg
`default_nettype wire

// ===== src/ethernet_mac_interrupt_aggregator.sv
// Interrupt flags, enables, summaries and status of an Ethernet MAC.
// Assumes event inputs come from DMA and MAC logic on mclk; only the
// PHY interrupt pin is asynchronous. Registers sit on Avalon-MM.
`default_nettype none

module ethernet_mac_interrupt_aggregator
  import emac_irq_pkg::*;
#(
  parameter int LEN_W = 14,          // Frame length counter width
  parameter int TS_W = 2,            // Number of timestamp causes
  parameter int NUM_ADDR = 4         // Perfect-filter address slots
) (
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [emac_irq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [emac_irq_pkg::DATA_W-1:0] writedata,
  output logic [emac_irq_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Event strobes from the MAC and DMA, one cycle each
  input wire logic tx_done_evt,
  input wire logic tx_stop_evt,
  input wire logic tx_no_desc_evt,
  input wire logic tx_underrun_evt,
  input wire logic tx_fifo_loaded_evt,
  input wire logic rx_done_evt,
  input wire logic rx_stop_evt,
  input wire logic rx_no_desc_evt,
  input wire logic rx_overrun_evt,
  input wire logic first_buf_evt,
  input wire logic bus_fault_evt,
  input wire logic [emac_irq_pkg::CAUSE_W-1:0] bus_fault_code,
  // Running frame lengths, checked while valid
  input wire logic rx_len_valid,
  input wire logic [LEN_W-1:0] rx_len,
  input wire logic tx_len_valid,
  input wire logic [LEN_W-1:0] tx_len,
  // Timestamp cause strobes
  input wire logic [TS_W-1:0] ts_event,
  // Asynchronous PHY interrupt pin, active high
  input wire logic phy_irq_pin,
  // Outputs toward processor and DMA
  output logic irq,
  output logic dma_enable,
  output logic jumbo_mode,
  output logic rx_suspend,
  output logic tx_suspend,
  output logic tx_abort,
  output logic rx_poll_demand,
  output logic tx_poll_demand
);
  import emac_irq_pkg::*;

  // Refuse shapes the logic cannot serve
  initial begin
    if (LEN_W < 14 || LEN_W > 16 || TS_W < 1 || TS_W > 16 || NUM_ADDR < 1) begin
      $error("unsupported parameter values");
    end
  end

  // Length limits at counter width
  localparam logic [LEN_W-1:0] NORMAL_LIM = LEN_W'(NORMAL_LIMIT);
  localparam logic [LEN_W-1:0] JUMBO_LIM = LEN_W'(JUMBO_LIMIT);
  localparam logic [DATA_W-1:0] NUM_ADDR_VAL = DATA_W'(NUM_ADDR);

  // Storage
  logic [NUM_SRC-2:0] flags_q;       // Sticky hardware flags, time sync excluded
  logic [NUM_SRC-1:0] enable_q;      // Source enables
  logic [TS_W-1:0] ts_cause_q;       // Sticky timestamp causes
  logic [TS_W-1:0] ts_enable_q;      // Timestamp cause enables
  logic dma_enable_q;
  logic jumbo_q;
  logic rx_suspend_q;
  logic tx_suspend_q;
  logic tx_abort_q;
  logic rx_poll_q;
  logic tx_poll_q;
  logic [CAUSE_W-1:0] cause_q;       // Last bus fault cause
  logic irq_q;
  logic [DATA_W-1:0] readdata_q;
  logic waitrequest_q;
  bus_state_t state_q;
  bus_state_t state_d;
  // PHY pin synchroniser and edge memory
  logic phy_meta_q;
  logic phy_sync_q;
  logic phy_prev_q;

  // Bus decode
  wire take_req = (read || write) && (state_q == ST_IDLE);
  wire acked = (state_q == ST_ACK);
  wire wr_ack = acked && write;
  wire rd_ack = acked && read;
  wire hit_raw = (address == RAW_STATUS_OFS);
  wire hit_mask = (address == MASKED_STATUS_OFS);
  wire hit_clr = (address == INT_CLEAR_OFS);
  wire hit_en = (address == INT_ENABLE_OFS);
  wire hit_tsen = (address == TS_ENABLE_OFS);
  wire hit_tsst = (address == TS_STATUS_OFS);
  wire hit_dma = (address == DMA_CTRL_OFS);
  wire hit_state = (address == DMA_STATE_OFS);
  wire hit_poll = (address == POLL_OFS);
  wire hit_num = (address == NUM_ADDR_OFS);

  // Synchronised PHY edge; only the second stage is looked at
  wire phy_edge = phy_sync_q && !phy_prev_q;

  // Length checks against the active limit
  wire [LEN_W-1:0] len_lim = jumbo_q ? JUMBO_LIM : NORMAL_LIM;
  wire rx_oversize = rx_len_valid && (rx_len > len_lim);
  wire tx_overlong = tx_len_valid && (tx_len > len_lim) && !tx_abort_q;

  // Hardware set vector, bit per source
  logic [NUM_SRC-2:0] set_vec;
  assign set_vec[TX_DONE_BIT] = tx_done_evt;
  // transmit stopped, also by overlong abort
  assign set_vec[TX_HALTED_BIT] = tx_stop_evt || tx_overlong;
  assign set_vec[TX_NODESC_BIT] = tx_no_desc_evt;
  assign set_vec[TX_OVERLONG_BIT] = tx_overlong;
  assign set_vec[RX_OVERRUN_BIT] = rx_overrun_evt;
  assign set_vec[TX_UNDERRUN_BIT] = tx_underrun_evt;
  assign set_vec[RX_DONE_BIT] = rx_done_evt;
  assign set_vec[RX_NODESC_BIT] = rx_no_desc_evt;
  assign set_vec[RX_HALTED_BIT] = rx_stop_evt;
  assign set_vec[RX_OVERSIZE_BIT] = rx_oversize;
  assign set_vec[TX_IN_FIFO_BIT] = tx_fifo_loaded_evt;
  assign set_vec[PHY_CHANGE_BIT] = phy_edge;
  assign set_vec[BUS_FAULT_BIT] = bus_fault_evt;
  assign set_vec[FIRST_RX_BUF_BIT] = first_buf_evt;

  // write-one clear, only the addressed bits
  wire [NUM_SRC-2:0] clr_vec = (wr_ack && hit_clr) ? writedata[NUM_SRC-2:0] : '0;
  // Set wins over a clear in the same cycle
  wire [NUM_SRC-2:0] flags_d = (flags_q & ~clr_vec) | set_vec;

  // timestamp status read clears the causes, new events win
  wire ts_rd_clr = rd_ack && hit_tsst;
  wire [TS_W-1:0] ts_cause_d = (ts_rd_clr ? '0 : ts_cause_q) | ts_event;
  // timestamp causes gated by their own enables
  wire time_sync = |(ts_cause_q & ts_enable_q);

  // Raw and masked views
  wire [NUM_SRC-1:0] raw_src = {time_sync, flags_q};
  wire [NUM_SRC-1:0] masked_src = raw_src & enable_q;
  wire normal_sum = |(masked_src & NORMAL_SET);
  wire abnormal_sum = |(masked_src & ABNORMAL_SET);
  wire [STATUS_W-1:0] raw_word = {normal_sum, abnormal_sum, raw_src};
  wire [STATUS_W-1:0] masked_word = {normal_sum, abnormal_sum, masked_src};
  // line follows summaries and remaining enabled sources
  wire irq_d = normal_sum || abnormal_sum || (|masked_src);

  // Read data mux; unmapped addresses read zero
  wire [DATA_W-1:0] rd_mux =
    hit_raw ? DATA_W'(raw_word) :
    hit_mask ? DATA_W'(masked_word) :
    hit_en ? DATA_W'(enable_q) :
    hit_tsen ? DATA_W'(ts_enable_q) :
    hit_tsst ? DATA_W'(ts_cause_q) :
    hit_dma ? DATA_W'({jumbo_q, dma_enable_q}) :
    // fault cause visible in DMA state
    hit_state ? DATA_W'({tx_suspend_q, rx_suspend_q, 1'b0, cause_q}) :
    hit_num ? NUM_ADDR_VAL : '0;

  // Control writes
  wire wr_en = wr_ack && hit_en;
  wire wr_tsen = wr_ack && hit_tsen;
  wire wr_dma = wr_ack && hit_dma;
  wire rx_poll = wr_ack && hit_poll && writedata[RX_POLL_BIT];
  wire tx_poll = wr_ack && hit_poll && writedata[TX_POLL_BIT];

  // fault disables DMA, overriding a software enable
  wire dma_en_d = bus_fault_evt ? 1'b0 : (wr_dma ? writedata[DMA_EN_BIT] : dma_enable_q);
  // suspend on missing descriptor, poll resumes, event wins
  wire rx_susp_d = rx_no_desc_evt || (rx_suspend_q && !rx_poll);
  // suspend on underrun or missing descriptor
  wire tx_susp_d = tx_underrun_evt || tx_no_desc_evt || (tx_suspend_q && !tx_poll);

  // Bus slave: one wait cycle, answer in the second
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_req) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q <= '0;
    end else begin
      state_q <= state_d;
      waitrequest_q <= !take_req;
      readdata_q <= take_req ? rd_mux : readdata_q;
    end
  end

  // PHY pin synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      phy_meta_q <= 1'b0;
      phy_sync_q <= 1'b0;
      phy_prev_q <= 1'b0;
    end else begin
      phy_meta_q <= phy_irq_pin;
      phy_sync_q <= phy_meta_q;
      phy_prev_q <= phy_sync_q;
    end
  end

  // Flags, enables and timestamp causes
  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q <= '0;
      enable_q <= ENABLE_RST;
      ts_cause_q <= '0;
      ts_enable_q <= '0;
    end else begin
      flags_q <= flags_d;
      enable_q <= wr_en ? writedata[NUM_SRC-1:0] : enable_q;
      ts_cause_q <= ts_cause_d;
      ts_enable_q <= wr_tsen ? writedata[TS_W-1:0] : ts_enable_q;
    end
  end

  // DMA control and process state
  always_ff @(posedge mclk) begin
    if (reset) begin
      dma_enable_q <= 1'b0;
      jumbo_q <= 1'b0;
      cause_q <= CAUSE_RST;
      rx_suspend_q <= 1'b0;
      tx_suspend_q <= 1'b0;
    end else begin
      dma_enable_q <= dma_en_d;
      jumbo_q <= wr_dma ? writedata[JUMBO_BIT] : jumbo_q;
      cause_q <= bus_fault_evt ? bus_fault_code : cause_q;
      rx_suspend_q <= rx_susp_d;
      tx_suspend_q <= tx_susp_d;
    end
  end

  // One-cycle strobes and the interrupt line
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_abort_q <= 1'b0;
      rx_poll_q <= 1'b0;
      tx_poll_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tx_abort_q <= tx_overlong;
      rx_poll_q <= rx_poll;
      tx_poll_q <= tx_poll;
      irq_q <= irq_d;
    end
  end

  // Ports straight from flops
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign irq = irq_q;
  assign dma_enable = dma_enable_q;
  assign jumbo_mode = jumbo_q;
  assign rx_suspend = rx_suspend_q;
  assign tx_suspend = tx_suspend_q;
  assign tx_abort = tx_abort_q;
  assign rx_poll_demand = rx_poll_q;
  assign tx_poll_demand = tx_poll_q;

  // Checks

  // Interrupt line lags the masked sources by one edge
  property p_irq_follows;
    @(posedge mclk) disable iff (reset)
      !$past(reset) |-> (irq_q == $past(irq_d));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq does not follow enabled sources");

  // Enabled transmit done reaches normal summary, then the line
  property p_normal;
    @(posedge mclk) disable iff (reset)
      tx_done_evt && enable_q[TX_DONE_BIT] && !wr_en |=> normal_sum ##1 irq_q;
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal summary missed transmit done");

  // Enabled bus fault reaches abnormal summary
  property p_abnormal;
    @(posedge mclk) disable iff (reset)
      bus_fault_evt && enable_q[BUS_FAULT_BIT] && !wr_en |=> abnormal_sum;
  endproperty
  a_abnormal: assert property (p_abnormal)
    else $error("abnormal summary missed bus fault");

  // Disabled source alone never raises the line
  property p_disabled_quiet;
    @(posedge mclk) disable iff (reset)
      (enable_q == '0) && $stable(enable_q) |=> !irq_q;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("irq raised with all sources disabled");

  // PHY pin rise is flagged within a few edges
  property p_phy;
    @(posedge mclk) disable iff (reset)
      $rose(phy_irq_pin) && !phy_meta_q && !phy_sync_q |-> ##[2:3] flags_q[PHY_CHANGE_BIT];
  endproperty
  a_phy: assert property (p_phy)
    else $error("PHY change not flagged");

  // Fault stops DMA and records its cause
  property p_fault;
    @(posedge mclk) disable iff (reset)
      bus_fault_evt |=> !dma_enable_q && flags_q[BUS_FAULT_BIT]
        && (cause_q == $past(bus_fault_code));
  endproperty
  a_fault: assert property (p_fault)
    else $error("bus fault handling wrong");

  // Oversize receive frame flagged next edge
  property p_oversize;
    @(posedge mclk) disable iff (reset)
      rx_len_valid && (rx_len > (jumbo_q ? JUMBO_LIM : NORMAL_LIM)) |=> flags_q[RX_OVERSIZE_BIT];
  endproperty
  a_oversize: assert property (p_oversize)
    else $error("oversize frame not flagged");

  // Overlong transmit: abort pulse, stopped and jabber flags
  sequence s_abort_pulse;
    tx_abort_q && flags_q[TX_OVERLONG_BIT] && flags_q[TX_HALTED_BIT];
  endsequence
  property p_overlong;
    @(posedge mclk) disable iff (reset)
      tx_overlong |=> s_abort_pulse;
  endproperty
  a_overlong: assert property (p_overlong)
    else $error("overlong transmit not aborted");

  // Missing receive descriptor suspends until a poll
  property p_rx_susp;
    @(posedge mclk) disable iff (reset)
      rx_no_desc_evt |=> rx_suspend_q && flags_q[RX_NODESC_BIT];
  endproperty
  a_rx_susp: assert property (p_rx_susp)
    else $error("receive not suspended");

  // Underrun suspends transmit
  property p_underrun;
    @(posedge mclk) disable iff (reset)
      tx_underrun_evt |=> tx_suspend_q && flags_q[TX_UNDERRUN_BIT];
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun not handled");

  // Clear without a new event drops the flag
  property p_clear;
    @(posedge mclk) disable iff (reset)
      wr_ack && hit_clr && writedata[RX_DONE_BIT] && !rx_done_evt |=> !flags_q[RX_DONE_BIT];
  endproperty
  a_clear: assert property (p_clear)
    else $error("selective clear failed");

  // Bus answer comes one cycle after the request is taken
  sequence s_ack;
    !waitrequest_q ##1 waitrequest_q;
  endsequence
  property p_bus;
    @(posedge mclk) disable iff (reset)
      take_req |=> s_ack;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer late");
endmodule : ethernet_mac_interrupt_aggregator
`default_nettype wire

// ===== tb/ethernet_mac_interrupt_aggregator_tb.sv
// Self-checking bench for the interrupt aggregator.
// Assumes the package constants and a one-wait Avalon slave.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module ethernet_mac_interrupt_aggregator_tb;
  import emac_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Status bit of each event input, in evt order
  localparam int SB [11] = '{0, 1, 2, 5, 10, 6, 8, 7, 4, 13, 12};
  logic mclk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [5:0] address = 6'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic waitrequest, irq, dma_enable, jumbo_mode, rx_suspend, tx_suspend;
  logic tx_abort, rx_poll_demand, tx_poll_demand, rx_len_valid = 1'b0, tx_len_valid = 1'b0;
  logic [10:0] evt = 11'h0, ev;
  logic [2:0] code = 3'h0, cex = CAUSE_RST, cr;
  logic [13:0] rx_len = 14'h0, tx_len = 14'h0;
  logic [1:0] ts_event = 2'h0;
  logic phy_irq_pin = 1'b0;
  logic [14:0] en, raw_e, clr;
  logic [15:0] host_rises;
  int mismatches = 0, samples_checked = 0, seed, rxp = 0, txp = 0, abn = 0, p0, p1;
  // Clock: 50 ns period
  always #25 mclk = ~mclk;
  // Pulse counters for the one-cycle outputs
  always @(posedge mclk) begin
    if (rx_poll_demand === 1'b1) rxp++;
    if (tx_poll_demand === 1'b1) txp++;
    if (tx_abort === 1'b1) abn++;
  end
  ethernet_mac_interrupt_aggregator #(.NUM_ADDR(5)) dut (.mclk(mclk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .tx_done_evt(evt[0]),
    .tx_stop_evt(evt[1]), .tx_no_desc_evt(evt[2]), .tx_underrun_evt(evt[3]),
    .tx_fifo_loaded_evt(evt[4]), .rx_done_evt(evt[5]), .rx_stop_evt(evt[6]),
    .rx_no_desc_evt(evt[7]), .rx_overrun_evt(evt[8]), .first_buf_evt(evt[9]),
    .bus_fault_evt(evt[10]), .bus_fault_code(code), .rx_len_valid(rx_len_valid),
    .rx_len(rx_len), .tx_len_valid(tx_len_valid), .tx_len(tx_len), .ts_event(ts_event),
    .phy_irq_pin(phy_irq_pin), .irq(irq), .dma_enable(dma_enable), .jumbo_mode(jumbo_mode),
    .rx_suspend(rx_suspend), .tx_suspend(tx_suspend), .tx_abort(tx_abort),
    .rx_poll_demand(rx_poll_demand), .tx_poll_demand(tx_poll_demand));
  irq_host_model host (.mclk(mclk), .reset(reset), .irq(irq), .rise_count(host_rises));
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // One Avalon transfer; waits for waitrequest low under a bound
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      conclude();
    end
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHK(nm, e, d)
  endtask : rd_chk
  // One-cycle strobes of events, lengths and timestamp causes
  task automatic drive(input logic [10:0] v, input logic lv, input logic [13:0] l,
                       input logic [1:0] ts, input logic [2:0] c);
    @(posedge mclk);
    evt <= v;
    rx_len_valid <= lv;
    tx_len_valid <= lv;
    rx_len <= l;
    tx_len <= l;
    ts_event <= ts;
    code <= c;
    @(posedge mclk);
    evt <= 11'h0;
    rx_len_valid <= 1'b0;
    tx_len_valid <= 1'b0;
    ts_event <= 2'h0;
  endtask : drive
  // Flags set by an event vector
  function automatic logic [14:0] map(input logic [10:0] v);
    map = 15'h0;
    for (int i = 0; i < 11; i++) if (v[i]) map[SB[i]] = 1'b1;
  endfunction : map
  // Expected status word; summaries always from masked sources
  function automatic logic [31:0] stat(input logic [14:0] r, input logic [14:0] e, input bit m);
    return {15'h0, |(r & e & NORMAL_SET), |(r & e & ABNORMAL_SET), m ? (r & e) : r};
  endfunction : stat
  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    conclude();
  end
  initial begin
    seed = 32'h4f6d;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd_chk("enable_rst", INT_ENABLE_OFS, 32'h0);
    rd_chk("raw_rst", RAW_STATUS_OFS, 32'h0);
    rd_chk("slots", NUM_ADDR_OFS, 32'h5);
    rd_chk("unmapped", 6'h28, 32'h0);
    // Disabled timestamp cause stays out of the raw status
    drive(11'h0, 1'b0, 14'h0, 2'h1, 3'h0);
    rd_chk("raw_ts_off", RAW_STATUS_OFS, 32'h0);
    rd_chk("ts_status_off", TS_STATUS_OFS, 32'h1);
    wr(TS_ENABLE_OFS, 32'h3);
    rd_chk("ts_enable", TS_ENABLE_OFS, 32'h3);
    // Timestamp flag ignores the general clear; its status read clears it
    drive(11'h0, 1'b0, 14'h0, 2'h1, 3'h0);
    wr(INT_CLEAR_OFS, 32'h7fff);
    rd_chk("raw_ts", RAW_STATUS_OFS, 32'h4000);
    rd_chk("ts_status", TS_STATUS_OFS, 32'h1);
    rd_chk("raw_ts_gone", RAW_STATUS_OFS, 32'h0);
    // PHY pin passes a two-stage synchroniser first
    phy_irq_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    phy_irq_pin <= 1'b0;
    rd_chk("phy", RAW_STATUS_OFS, 32'h800);
    wr(INT_CLEAR_OFS, 32'h800);
    rd_chk("phy_clr", RAW_STATUS_OFS, 32'h0);
    // Frame length limits at the boundary, normal and jumbo
    for (int k = 0; k < 4; k++) begin
      wr(DMA_CTRL_OFS, {30'h0, k[1], 1'b1});
      p0 = abn;
      drive(11'h0, 1'b1, 14'((k > 1 ? JUMBO_LIMIT : NORMAL_LIMIT) + k % 2), 2'h0, 3'h0);
      `CHK("jumbo", k[1], jumbo_mode)
      repeat (2) @(posedge mclk);
      `CHK("abort", p0 + k % 2, abn)
      rd_chk("oversize", RAW_STATUS_OFS, k[0] ? 32'h20a : 32'h0);
      wr(INT_CLEAR_OFS, 32'h7fff);
      wr(POLL_OFS, 32'h3);
    end
    // Random event mixes; first is every event at once
    for (int it = 0; it < 24; it++) begin
      ev = (it == 0) ? 11'h7ff : 11'($random(seed));
      en = (it == 1) ? 15'h7fff : 15'($random(seed));
      cr = 3'($random(seed));
      wr(DMA_CTRL_OFS, 32'h1);
      wr(INT_ENABLE_OFS, {17'h0, en});
      drive(ev, 1'b0, 14'h0, 2'h0, cr);
      raw_e = map(ev);
      if (ev[10]) cex = cr;
      rd_chk("raw", RAW_STATUS_OFS, stat(raw_e, en, 1'b0));
      rd_chk("masked", MASKED_STATUS_OFS, stat(raw_e, en, 1'b1));
      `CHK("irq", |(raw_e & en), irq)
      `CHK("dma_enable", !ev[10], dma_enable)
      rd_chk("dma_state", DMA_STATE_OFS, {26'h0, ev[2] | ev[3], ev[7], 1'b0, cex});
      p0 = rxp;
      p1 = txp;
      wr(POLL_OFS, 32'h3);
      repeat (3) @(posedge mclk);
      `CHK("polls", {p0 + 1, p1 + 1}, {rxp, txp})
      `CHK("suspends", 2'b00, {rx_suspend, tx_suspend})
      clr = 15'($random(seed));
      wr(INT_CLEAR_OFS, {17'h0, clr});
      raw_e = raw_e & ~clr;
      rd_chk("cleared", RAW_STATUS_OFS, stat(raw_e, en, 1'b0));
      repeat (2) @(posedge mclk);
      `CHK("irq_after_clear", |(raw_e & en), irq)
      // Handler clears everything it served
      wr(INT_CLEAR_OFS, 32'h7fff);
      repeat (3) @(posedge mclk);
      `CHK("irq_idle", 1'b0, irq)
    end
    `CHK("host_saw_irq", 1'b1, host_rises > 16'h0)
    conclude();
  end
endmodule : ethernet_mac_interrupt_aggregator_tb
`undef CHK
`default_nettype wire

// ===== tb/irq_host_model.sv
// Processor-side interrupt controller model: watches the interrupt line.
// Assumes irq is a level synchronous to mclk.
`default_nettype none
module irq_host_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic irq,
  output logic [15:0] rise_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q; // Previous line level
  // Count each new request, as a handler entry would
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_q <= 1'b0;
      rise_count <= 16'h0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) begin
        rise_count <= rise_count + 16'h1;
      end
    end
  end
endmodule : irq_host_model
`default_nettype wire
